//--- pkg/throttle_consts.svh
`ifndef THROTTLE_CONSTS_SVH
`define THROTTLE_CONSTS_SVH

// ***********************************************************
// timing figures
// ***********************************************************
`define CLK_PERIOD_PS        5000
`define MAX_OFF_TIME_NS      3000
`define MAX_OFF_CYCLES       ((`MAX_OFF_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define DEF_PERIOD_CYCLES    1000
`define DEF_ON_PCT           40
`define DEF_HYST_CYCLES      20000
`define DEF_FILT_CYCLES      4
`define MIN_ON_PCT           30
`define MAX_ON_PCT           50

// ***********************************************************
// reset values
// ***********************************************************
`define RST_CLK_RUN          1'b1
`define RST_ACTIVE           1'b0

`endif

//--- pkg/throttle_pkg.sv
package throttle_pkg;

  // throttle controller states, gray along idle-active-hyst
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_HYST   = 2'b11
  } tcc_state_t;

  // on-demand request from software side
  typedef struct packed {
    logic       enable;
    logic [2:0] duty;
  } ondemand_t;

  // clock gate outputs toward the core clock tree
  typedef struct packed {
    logic clk_run;
    logic snoop_run;
    logic irq_release;
  } gate_ctl_t;

endpackage : throttle_pkg

//--- rtl/duty_modulator.sv
`include "throttle_consts.svh"

// ***********************************************************
// on/off clock modulator with fixed or selectable duty
// ***********************************************************
module duty_modulator #(
  parameter int PERIOD_CYCLES = `DEF_PERIOD_CYCLES,
  parameter int ON_PCT        = `DEF_ON_PCT
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic        use_fixed,
  input  wire logic [2:0]  sel_duty,
  output logic             clk_on
);
  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CW-1:0] PER_LAST  = CW'(PERIOD_CYCLES - 1);
  localparam logic [CW-1:0] FIXED_ON  = CW'((PERIOD_CYCLES * ON_PCT) / 100);
  localparam logic [CW-1:0] EIGHTH    = CW'(PERIOD_CYCLES / 8);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          on_reg;
  logic          on_next;
  logic [CW-1:0] on_len;
  logic          fixed_reg;
  logic          fixed_next;

  // refuse periods and duties the counter cannot serve
  if (PERIOD_CYCLES < 8 || ON_PCT < 1 || ON_PCT > 100) begin : g_bad_cfg
    $error("modulator period or duty unusable");
  end

  // on length: fixed value wins over software selection
  always_comb begin
    if (use_fixed || sel_duty == 3'h0) begin
      on_len = FIXED_ON;
    end else begin
      on_len = CW'(EIGHTH * sel_duty);
    end
  end

  // period counter and on window; a change of duty source restarts the period
  always_comb begin
    cnt_next   = cnt_reg;
    on_next    = 1'b1;
    fixed_next = use_fixed;
    if (!run) begin
      cnt_next = '0;
    end else if (use_fixed != fixed_reg) begin
      cnt_next = '0;
    end else begin
      cnt_next = (cnt_reg == PER_LAST) ? '0 : cnt_reg + CW'(1);
      on_next  = (cnt_next < on_len);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg   <= '0;
      on_reg    <= `RST_CLK_RUN;
      fixed_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      on_reg    <= on_next;
      fixed_reg <= fixed_next;
    end
  end

  assign clk_on = on_reg;

endmodule : duty_modulator

//--- rtl/thermal_clock_throttle.sv
// Functional notes
// - enabled monitor plus hot die starts modulation
// - thermal modulation keeps clocks on 30 to 50 percent
// - thermal duty fixed at build, no control path
// - each thermal off interval at most 3 us
// - period counted in core clock cycles
// - trip point fixed, never reported
// - snooping continues through off intervals
// - interrupts held, released only when clocks on
// - stop after cool plus hysteresis expiry
// - thermal throttling fully autonomous, no software involvement
// - thermal duty overrides on-demand duty
// - hot pin driven low, external low forces
`include "throttle_consts.svh"

module thermal_clock_throttle
  import throttle_pkg::*;
#(
  parameter int PERIOD_CYCLES = `DEF_PERIOD_CYCLES,
  parameter int ON_PCT        = `DEF_ON_PCT,
  parameter int HYST_CYCLES   = `DEF_HYST_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    monitor_en,
  input  wire logic                    die_trip,
  input  wire logic                    overtemp_indicator_pin_n_in,
  output logic                         overtemp_indicator_pin_n_out,
  output logic                         overtemp_indicator_pin_n_oe,
  input  wire throttle_pkg::ondemand_t ondemand,
  input  wire logic                    irq_req,
  output throttle_pkg::gate_ctl_t      gate,
  output logic                         tcc_active
);
  import throttle_pkg::*;

  localparam int OFF_CYCLES = PERIOD_CYCLES - (PERIOD_CYCLES * ON_PCT) / 100;
  localparam int HW = $clog2(HYST_CYCLES + 1);
  localparam logic [HW-1:0] HYST_LAST = HW'(HYST_CYCLES - 1);

  // ***********************************************************
  // elaboration checks
  // ***********************************************************
  if (ON_PCT < `MIN_ON_PCT || ON_PCT > `MAX_ON_PCT) begin : g_bad_pct
    $error("on percentage out of range");
  end
  if (OFF_CYCLES > `MAX_OFF_CYCLES) begin : g_bad_off
    $error("off interval too long");
  end
  if (OFF_CYCLES < 1 || PERIOD_CYCLES < 8 || HYST_CYCLES < 1) begin : g_bad_size
    $error("period, off interval or hysteresis too small");
  end

  // ***********************************************************
  // input synchronisers
  // ***********************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_reg;
  logic [2:0] sync2_next;
  logic       en_s;
  logic       trip_s;
  logic       ext_hot_s;

  // capture pins; first stage read only by second
  always_comb begin
    sync1_next = {monitor_en, die_trip, ~overtemp_indicator_pin_n_in};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign en_s      = sync2_reg[2];
  assign trip_s    = sync2_reg[1];
  assign ext_hot_s = sync2_reg[0];

  // ***********************************************************
  // over-temperature pin
  // ***********************************************************
  logic       drive_reg;
  logic       drive_next;
  logic [1:0] drive_dly_reg;
  logic [1:0] drive_dly_next;
  logic       ext_hot;

  // drive low while own sensor trips; delay line follows the loopback
  always_comb begin
    drive_next     = en_s & trip_s;
    drive_dly_next = {drive_dly_reg[0], drive_reg};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drive_reg     <= 1'b0;
      drive_dly_reg <= 2'h0;
    end else begin
      drive_reg     <= drive_next;
      drive_dly_reg <= drive_dly_next;
    end
  end

  assign overtemp_indicator_pin_n_out = 1'b0;
  assign overtemp_indicator_pin_n_oe  = drive_reg;
  // own drive returns through the synchroniser two cycles late; mask it
  // exactly there, else releasing the pin would retrigger the throttle
  assign ext_hot = ext_hot_s & ~drive_dly_reg[1];

  // ***********************************************************
  // thermal control state machine
  // ***********************************************************
  tcc_state_t    state_reg;
  tcc_state_t    state_next;
  logic [HW-1:0] hyst_reg;
  logic [HW-1:0] hyst_next;
  logic          hot;

  // hot from fixed internal trip or external force; no threshold input
  assign hot = en_s & (trip_s | ext_hot);

  // autonomous start, hysteresis hold and stop
  always_comb begin
    state_next = state_reg;
    hyst_next  = hyst_reg;
    case (state_reg)
      ST_IDLE: begin
        hyst_next = '0;
        if (hot) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        hyst_next = '0;
        if (!hot) begin
          state_next = ST_HYST;
        end
      end
      ST_HYST: begin
        if (hot) begin
          state_next = ST_ACTIVE;
          hyst_next  = '0;
        end else if (hyst_reg == HYST_LAST) begin
          state_next = ST_IDLE;
          hyst_next  = '0;
        end else begin
          hyst_next = hyst_reg + HW'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
        hyst_next  = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      hyst_reg  <= '0;
    end else begin
      state_reg <= state_next;
      hyst_reg  <= hyst_next;
    end
  end

  logic tcc_run;
  assign tcc_run = (state_reg != ST_IDLE);

  // ***********************************************************
  // clock modulation
  // ***********************************************************
  logic mod_run;
  logic clk_on;

  // thermal or on-demand request runs the modulator
  assign mod_run = tcc_run | ondemand.enable;

  duty_modulator #(
    .PERIOD_CYCLES (PERIOD_CYCLES),
    .ON_PCT        (ON_PCT)
  ) u_mod (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .run       (mod_run),
    .use_fixed (tcc_run),
    .sel_duty  (ondemand.duty),
    .clk_on    (clk_on)
  );

  // ***********************************************************
  // interrupt holding
  // ***********************************************************
  logic irq_hold_reg;
  logic irq_hold_next;

  // latch requests; release while clocks run
  always_comb begin
    irq_hold_next = irq_hold_reg;
    if (irq_req) begin
      irq_hold_next = 1'b1;
    end else if (clk_on) begin
      irq_hold_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_hold_reg <= 1'b0;
    end else begin
      irq_hold_reg <= irq_hold_next;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  logic tcc_out_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tcc_out_reg <= `RST_ACTIVE;
    end else begin
      tcc_out_reg <= tcc_run;
    end
  end

  assign gate.clk_run     = clk_on;
  assign gate.snoop_run   = 1'b1;
  assign gate.irq_release = (irq_hold_reg | irq_req) & clk_on;
  assign tcc_active       = tcc_out_reg;

endmodule : thermal_clock_throttle

//--- testbench/tcc_checker.sv
// ***********************************************************
// port checker for the throttle block
// ***********************************************************
module tcc_checker #(
  parameter int PERIOD_CYCLES = 20,
  parameter int ON_PCT        = 40,
  parameter int HYST_CYCLES   = 20
) (
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire logic                    monitor_en,
  input wire logic                    die_trip,
  input wire logic                    overtemp_indicator_pin_n_in,
  input wire logic                    overtemp_indicator_pin_n_out,
  input wire logic                    overtemp_indicator_pin_n_oe,
  input wire logic                    irq_req,
  input wire throttle_pkg::ondemand_t ondemand,
  input wire throttle_pkg::gate_ctl_t gate,
  input wire logic                    tcc_active
);
  timeunit 1ns;
  timeprecision 1ps;
  import throttle_pkg::*;
  localparam int ON_C  = PERIOD_CYCLES * ON_PCT / 100;
  localparam int OFF_C = PERIOD_CYCLES - ON_C;
  logic        hot;
  logic [15:0] cool_reg;
  logic [15:0] cool_next;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // consecutive cool cycles, saturating
  assign hot = monitor_en & (die_trip | ~overtemp_indicator_pin_n_in);
  always_comb begin
    cool_next = hot ? 16'h0000 : cool_reg + {15'h0000, cool_reg != 16'hFFFF};
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cool_reg <= 16'h0000;
    else cool_reg <= cool_next;
  end
  property p_drive_low; overtemp_indicator_pin_n_out == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin driven high");
  property p_oe; (monitor_en && die_trip)[*4] |-> overtemp_indicator_pin_n_oe; endproperty
  a_oe: assert property (p_oe) else $error("hot pin not pulled");
  property p_snoop; gate.snoop_run; endproperty
  a_snoop: assert property (p_snoop) else $error("snoop stopped");
  property p_irq; gate.irq_release |-> gate.clk_run; endproperty
  a_irq: assert property (p_irq) else $error("irq released while off");
  property p_irq_held; irq_req && !gate.clk_run |-> ##[1:OFF_C] gate.irq_release; endproperty
  a_irq_held: assert property (p_irq_held) else $error("held irq lost");
  property p_start; (monitor_en && die_trip)[*5] |-> tcc_active; endproperty
  a_start: assert property (p_start) else $error("throttle not started");
  property p_off; $fell(gate.clk_run) && tcc_active |-> ##[1:OFF_C] gate.clk_run; endproperty
  a_off: assert property (p_off) else $error("off interval too long");
  property p_on; $fell(gate.clk_run) && tcc_active |-> $past(gate.clk_run, ON_C); endproperty
  a_on: assert property (p_on) else $error("on interval too short");
  property p_hyst; $fell(tcc_active) |-> cool_reg >= HYST_CYCLES; endproperty
  a_hyst: assert property (p_hyst) else $error("left throttle early");
  property p_stop; cool_reg == HYST_CYCLES + 8 |-> !tcc_active; endproperty
  a_stop: assert property (p_stop) else $error("throttle never stopped");
  property p_idle; (!tcc_active && !ondemand.enable) [*2] |-> gate.clk_run; endproperty
  a_idle: assert property (p_idle) else $error("clocks gated while idle");
  c_rise: cover property ($rose(tcc_active));
  c_fall: cover property ($fell(tcc_active));
  c_irq: cover property ($rose(gate.irq_release) && !irq_req);
endmodule : tcc_checker

bind thermal_clock_throttle tcc_checker #(
  .PERIOD_CYCLES(PERIOD_CYCLES), .ON_PCT(ON_PCT), .HYST_CYCLES(HYST_CYCLES)
) chk_u (
  .ref_clk(ref_clk), .rstn(rstn), .monitor_en(monitor_en), .die_trip(die_trip),
  .overtemp_indicator_pin_n_in(overtemp_indicator_pin_n_in),
  .overtemp_indicator_pin_n_out(overtemp_indicator_pin_n_out),
  .overtemp_indicator_pin_n_oe(overtemp_indicator_pin_n_oe),
  .irq_req(irq_req), .ondemand(ondemand), .gate(gate), .tcc_active(tcc_active)
);

//--- testbench/far_side_model.sv
// ***********************************************************
// pulled-up hot pin with an external forcing agent
// ***********************************************************
module far_side_model (
  input wire logic force_hot,
  input wire logic dut_oe,
  output logic     pin_n,
  output logic     fan_full
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired low by either party, pull-up otherwise
  assign pin_n = ~(dut_oe | force_hot);
  assign fan_full = ~pin_n;
endmodule : far_side_model

//--- testbench/tb_top.sv
// ***********************************************************
// throttle testbench
// ***********************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import throttle_pkg::*;
  localparam int PER = 20;
  localparam int ON  = 8;
  localparam int HY  = 20;
  logic        ref_clk, rstn, monitor_en, die_trip, force_hot, pin_n, oe, irq_req, tcc_active;
  ondemand_t   ondemand;
  gate_ctl_t   gate;
  logic [31:0] lfsr;
  int          errors, checked, on_n, off_n, k;
  thermal_clock_throttle #(.PERIOD_CYCLES(PER), .ON_PCT(40), .HYST_CYCLES(HY)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .monitor_en(monitor_en), .die_trip(die_trip),
    .overtemp_indicator_pin_n_in(pin_n), .overtemp_indicator_pin_n_out(),
    .overtemp_indicator_pin_n_oe(oe), .ondemand(ondemand), .irq_req(irq_req),
    .gate(gate), .tcc_active(tcc_active));
  far_side_model fs_u (.force_hot(force_hot), .dut_oe(oe), .pin_n(pin_n), .fan_full());
  function logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  function int exp_on(input int d);
    return (d == 0) ? ON : (PER / 8) * d;
  endfunction : exp_on
  task compare(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : compare
  task close_out;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task wait_sig(input logic v, input logic which, input int lim);
    k = 0;
    while ((which ? tcc_active : gate.clk_run) !== v && k < lim) begin
      tick(1);
      k++;
    end
    if ((which ? tcc_active : gate.clk_run) !== v) begin
      errors++;
      close_out;
    end
  endtask : wait_sig
  // skip to a clean period start, then count one full on and one full off
  task measure;
    wait_sig(1'b1, 1'b0, 200);
    wait_sig(1'b0, 1'b0, 200);
    wait_sig(1'b1, 1'b0, 200);
    off_n = 0;
    on_n = 0;
    while (gate.clk_run === 1'b1 && on_n < 200) begin tick(1); on_n++; end
    while (gate.clk_run === 1'b0 && off_n < 200) begin tick(1); off_n++; end
  endtask : measure
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    errors++;
    close_out;
  end
  // main sequence
  initial begin
    {rstn, monitor_en, die_trip, force_hot, irq_req} = 5'h00;
    ondemand = '0;
    lfsr = 32'h0033;
    errors = 0;
    checked = 0;
    tick(12);
    rstn = 1'b1;
    tick(4);
    compare(gate.clk_run, 1);
    for (int d = 0; d < 8; d++) begin
      ondemand.enable = 1'b1;
      ondemand.duty = 3'(d);
      tick(2);
      measure;
      compare(on_n, exp_on(d));
      compare(on_n + off_n, PER);
    end
    die_trip = 1'b1;
    tick(30);
    compare(tcc_active, 0);
    lfsr = step(lfsr);
    ondemand.duty = lfsr[2:0] | 3'h1;
    monitor_en = 1'b1;
    wait_sig(1'b1, 1'b1, 10);
    compare(oe, 1);
    measure;
    compare(on_n, ON);
    compare(off_n, PER - ON);
    wait_sig(1'b0, 1'b0, 40);
    tick(1);
    irq_req = 1'b1;
    tick(1);
    irq_req = 1'b0;
    compare(gate.irq_release, 0);
    wait_sig(1'b1, 1'b0, 40);
    compare(gate.irq_release, 1);
    // on-demand off so that the end of throttling must stop all gating
    ondemand = '0;
    die_trip = 1'b0;
    tick(10);
    die_trip = 1'b1;
    tick(1);
    die_trip = 1'b0;
    tick(HY);
    compare(tcc_active, 1);
    wait_sig(1'b0, 1'b1, 40);
    compare(gate.clk_run, 1);
    tick(PER);
    compare(gate.clk_run, 1);
    force_hot = 1'b1;
    wait_sig(1'b1, 1'b1, 10);
    compare(oe, 0);
    force_hot = 1'b0;
    for (int r = 0; r < 40; r++) begin
      lfsr = step(lfsr);
      die_trip = lfsr[3];
      irq_req = lfsr[7];
      tick(1 + int'(lfsr[12:8]));
    end
    {die_trip, irq_req} = 2'h0;
    wait_sig(1'b0, 1'b1, 80);
    compare(gate.clk_run, 1);
    close_out;
  end
endmodule : tb_top
